// ===== hdl/wake_timer.sv
// Periodic wake-up and reset timer with a thermal restart gate.
// Assumes AXI4-Lite on CLK, oscillator tick and thermal inputs from pins.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module wake_timer
  import wake_timer_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CORE_RST,
  input wire logic CE,
  // Oscillator tick and thermal comparators from pins
  input wire logic OSC_TICK,
  input wire logic TEMP_IN_RESET,
  input wire logic TEMP_IN_REARM,
  input wire logic TEMP_LIMIT,
  // AXI4-Lite write address
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [15:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Core-facing outputs
  output logic WAKE_IRQ,
  output logic CORE_RESTART,
  output logic STOP_REQ,
  output logic TR_POWER
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] sync1_reg; // First stage only feeds the second
  logic [3:0] sync2_reg; // Settled pin levels
  logic tick_prev_reg; // For tick edge detection
  logic tick_pulse; // One CLK pulse per oscillator tick

  // Two flip-flops on every pin input
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      tick_prev_reg <= 1'b0;
    end else if (CE) begin
      sync1_reg <= {TEMP_LIMIT, TEMP_IN_REARM, TEMP_IN_RESET, OSC_TICK};
      sync2_reg <= sync1_reg;
      tick_prev_reg <= sync2_reg[0];
    end
  end

  assign tick_pulse = sync2_reg[0] & ~tick_prev_reg;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [5:0] div_reg; // Wake divider value, power-on only
  logic [5:0] wake_lim_reg; // Wake interval setting
  logic [5:0] rst_lim_reg; // Reset interval setting
  logic wake_en_reg; // Wake interrupt enable
  logic rst_en_reg; // Periodic reset enable
  logic psel_reg; // Counter read-back select
  logic tre_reg; // Restart enable
  logic trh_reg; // High threshold select
  logic armed_reg; // Restart armed status
  logic flag_reg; // Wake interrupt flag

  // ****************************************************************
  // Prescaler and cascaded counters
  // ****************************************************************
  logic [10:0] pre_reg; // Prescaler tick count
  logic [5:0] wake_cnt_reg; // Wake interval counter
  logic [5:0] rst_cnt_reg; // Reset interval counter
  logic wclk; // Wake clock pulse
  logic wake_hit; // Wake interval reached
  logic rst_hit; // Reset interval reached
  logic gated; // Thermal gate active

  // Period in ticks for a given divider value
  function automatic logic [10:0] div_period(input logic [5:0] d);
    div_period = {1'b0, DIV_BASE} + ({5'h00, d} << DIV_STEP_SHIFT);
  endfunction

  assign wclk = tick_pulse && (pre_reg == div_period(div_reg) - 11'd1);
  assign wake_hit = wclk && (wake_cnt_reg == wake_lim_reg);
  assign rst_hit = wake_hit && (rst_cnt_reg == rst_lim_reg);
  assign gated = tre_reg & armed_reg;

  // Prescaler runs free with no power-down control
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_reg <= 11'h000;
    end else if (CE && tick_pulse) begin
      if (wclk) begin
        pre_reg <= 11'h000;
      end else begin
        pre_reg <= pre_reg + 11'd1;
      end
    end
  end

  // Wake counter increments then clears on match
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wake_cnt_reg <= 6'h00;
    end else if (CE && wclk) begin
      if (wake_hit) begin
        wake_cnt_reg <= 6'h00;
      end else begin
        wake_cnt_reg <= wake_cnt_reg + 6'd1;
      end
    end
  end

  // Reset counter counts wake pulses
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rst_cnt_reg <= 6'h00;
    end else if (CE && wake_hit) begin
      if (rst_hit) begin
        rst_cnt_reg <= 6'h00;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 6'd1;
      end
    end
  end

  // ****************************************************************
  // Thermal restart unit
  // ****************************************************************
  logic in_reset; // Temperature in reset range
  logic in_rearm; // Temperature in rearm range
  logic recover; // Armed unit sees recovery
  assign in_reset = sync2_reg[1];
  assign in_rearm = sync2_reg[2];
  assign recover = tre_reg && armed_reg && in_reset;

  // Armed status: set on core reset or on leaving rearm range
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      armed_reg <= 1'b1;
    end else if (CE) begin
      if (CORE_RST || (!in_rearm && tick_pulse)) begin
        armed_reg <= 1'b1;
      end else if (in_reset && tick_pulse && !tre_reg) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic aw_hold_reg; // Write address captured
  logic w_hold_reg; // Write data captured
  logic [15:0] awaddr_reg; // Captured write address
  logic [31:0] wdata_reg; // Captured write data
  logic [3:0] wstrb_reg; // Captured strobes
  logic do_write; // Both halves present
  logic wr_map; // Write address is mapped
  logic rd_map; // Read address is mapped
  logic [31:0] rd_word; // Read mux

  assign do_write = aw_hold_reg && w_hold_reg && !BVALID;

  // Address decode shared by both directions
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == OFS_WAKE_DIV) || (a == OFS_WAKE_INTERVAL) ||
      (a == OFS_RESET_INTERVAL) || (a == OFS_WAKE_STATUS) ||
      (a == OFS_OPTION_ONE) || (a == OFS_TEST_STATUS);
  endfunction

  assign wr_map = is_mapped(awaddr_reg);
  assign rd_map = is_mapped(ARADDR);

  // Capture address and data in either order
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 16'h0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end else if (CE) begin
      AWREADY <= !aw_hold_reg && !AWREADY && AWVALID;
      WREADY <= !w_hold_reg && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Timer settings; divider held across core resets
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_reg <= DIV_POR;
      wake_lim_reg <= INTERVAL_RST;
      rst_lim_reg <= INTERVAL_RST;
      wake_en_reg <= 1'b1;
      rst_en_reg <= 1'b0;
      psel_reg <= 1'b0;
    end else if (CE && do_write && wstrb_reg[0]) begin
      if (awaddr_reg == OFS_WAKE_DIV) begin
        div_reg <= wdata_reg[5:0];
      end
      if (awaddr_reg == OFS_WAKE_INTERVAL) begin
        wake_lim_reg <= wdata_reg[5:0];
      end
      if (awaddr_reg == OFS_RESET_INTERVAL) begin
        rst_lim_reg <= wdata_reg[5:0];
        // Neither-enabled coding falls back to wake only
        wake_en_reg <= wdata_reg[WAKE_EN_BIT] | ~wdata_reg[RST_EN_BIT];
        rst_en_reg <= wdata_reg[RST_EN_BIT];
      end
      if (awaddr_reg == OFS_WAKE_STATUS) begin
        psel_reg <= wdata_reg[PSEL_BIT];
      end
    end
  end

  // Thermal control bits, cleared by any core reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tre_reg <= 1'b0;
      trh_reg <= 1'b0;
    end else if (CE) begin
      if (CORE_RST) begin
        tre_reg <= 1'b0;
        trh_reg <= 1'b0;
      end else if (do_write && wstrb_reg[0] &&
                   awaddr_reg == OFS_OPTION_ONE) begin
        trh_reg <= wdata_reg[OPT_BYTE_LSB + TRH_BIT];
        if (armed_reg || !wdata_reg[OPT_BYTE_LSB + TRE_BIT]) begin
          tre_reg <= wdata_reg[OPT_BYTE_LSB + TRE_BIT];
        end
      end
    end
  end

  // Wake flag; a new event wins over an acknowledge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flag_reg <= 1'b0;
    end else if (CE) begin
      if (wake_hit && wake_en_reg && !gated &&
          !(rst_hit && rst_en_reg)) begin
        flag_reg <= 1'b1;
      end else if (do_write && wstrb_reg[0] &&
                   awaddr_reg == OFS_WAKE_INTERVAL &&
                   wdata_reg[ACK_BIT]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // Read mux; acknowledge bit reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ARADDR == OFS_WAKE_DIV) begin
      rd_word[5:0] = div_reg;
    end else if (ARADDR == OFS_WAKE_INTERVAL) begin
      rd_word[5:0] = wake_lim_reg;
      rd_word[FLAG_BIT] = flag_reg;
    end else if (ARADDR == OFS_RESET_INTERVAL) begin
      rd_word[5:0] = rst_lim_reg;
      rd_word[RST_EN_BIT] = rst_en_reg;
      rd_word[WAKE_EN_BIT] = wake_en_reg;
    end else if (ARADDR == OFS_WAKE_STATUS) begin
      rd_word[CNT_LSB +: 6] = psel_reg ? rst_cnt_reg : wake_cnt_reg;
      rd_word[PSEL_BIT] = psel_reg;
    end else if (ARADDR == OFS_OPTION_ONE) begin
      rd_word[OPT_BYTE_LSB + TRE_BIT] = tre_reg;
      rd_word[OPT_BYTE_LSB + TRH_BIT] = trh_reg;
    end else if (ARADDR == OFS_TEST_STATUS) begin
      rd_word[TST_BYTE_LSB + ARMED_BIT] = armed_reg;
    end
  end

  // Read channel, one cycle to answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (CE) begin
      ARREADY <= ARVALID && !ARREADY && !RVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Core-facing outputs
  // ****************************************************************
  // Interrupt follows the flag with no mask; restart on match or recovery
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WAKE_IRQ <= 1'b0;
      CORE_RESTART <= 1'b0;
      STOP_REQ <= 1'b0;
      TR_POWER <= 1'b0;
    end else if (CE) begin
      WAKE_IRQ <= flag_reg;
      CORE_RESTART <= (rst_hit && rst_en_reg && !gated) || recover;
      STOP_REQ <= tre_reg && sync2_reg[3];
      TR_POWER <= tre_reg;
    end
  end

endmodule

`default_nettype wire

// ===== common/wake_timer_pkg.sv
// Constants for the periodic wake-up timer with thermal gate.
// Assumes an AXI4-Lite master and a 25 MHz system clock.
`default_nettype none
package wake_timer_pkg;

  // ****************************************************************
  // Register indices; a register's byte address is four times its index
  // ****************************************************************
  localparam logic [15:0] IDX_WAKE_DIV = 16'h0038;
  localparam logic [15:0] IDX_OPTION_ONE = 16'h1802;
  localparam logic [15:0] IDX_TEST_STATUS = 16'h180F;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [15:0] OFS_WAKE_DIV = IDX_WAKE_DIV << 2;
  localparam logic [15:0] OFS_WAKE_INTERVAL = 16'h0040;
  localparam logic [15:0] OFS_RESET_INTERVAL = 16'h0044;
  localparam logic [15:0] OFS_WAKE_STATUS = 16'h0048;
  localparam logic [15:0] OFS_OPTION_ONE = IDX_OPTION_ONE << 2;
  localparam logic [15:0] OFS_TEST_STATUS = IDX_TEST_STATUS << 2;

  // ****************************************************************
  // Field positions, reset values and divider constants
  // ****************************************************************
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int PSEL_BIT = 0;
  localparam int RST_EN_BIT = 6;
  localparam int WAKE_EN_BIT = 7;
  localparam int OPT_BYTE_LSB = 0;
  localparam int TRE_BIT = 3;
  localparam int TRH_BIT = 2;
  localparam int TST_BYTE_LSB = 0;
  localparam int CNT_LSB = 8;
  localparam int ARMED_BIT = 0;
  localparam logic [5:0] DIV_POR = 6'h1F;
  localparam logic [5:0] INTERVAL_RST = 6'h3F;
  localparam logic [9:0] DIV_BASE = 10'h1F8;
  localparam int DIV_STEP_SHIFT = 4;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// ===== verif/core_model.sv
// Behavioural core on the far side of the wake timer.
// Assumes the timer's clock and power-on reset; counts events it sees.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wake and restart from the timer
  input wire logic wake_irq,
  input wire logic restart,
  // Reset of the core back into the timer
  output logic core_rst,
  // Event counts
  output logic [7:0] wakes,
  output logic [7:0] restarts
);
  // ********
  // Event history
  // ********
  logic irq_d; // Wake line one cycle ago
  logic rst_d; // Restart line one cycle ago
  // Count rising edges of wake and restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_d <= 1'b0;
      rst_d <= 1'b0;
      wakes <= 8'h00;
      restarts <= 8'h00;
    end else begin
      irq_d <= wake_irq;
      rst_d <= restart;
      wakes <= wakes + {7'h00, wake_irq && !irq_d};
      restarts <= restarts + {7'h00, restart && !rst_d};
    end
  end
  // A restarted core resets itself for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_rst <= 1'b0;
    end else begin
      core_rst <= restart && !rst_d;
    end
  end
endmodule
`default_nettype wire

// ===== verif/wake_timer_asserts.sv
// Checker for the wake timer's bus handshakes and core outputs.
// Assumes it is bound to wake_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wake_timer_asserts
  import wake_timer_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus handshakes and write data
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  // Thermal pins and core outputs
  input wire logic TEMP_IN_RESET,
  input wire logic TEMP_LIMIT,
  input wire logic WAKE_IRQ,
  input wire logic CORE_RESTART,
  input wire logic STOP_REQ,
  input wire logic TR_POWER
);
  // ********
  // Helper logic
  // ********
  logic [3:0] ack_age; // Cycles since a write with the acknowledge bit
  // Age of the last acknowledge, saturating
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_age <= 4'hF;
    end else if (WVALID && WREADY && WDATA[ACK_BIT]) begin
      ack_age <= 4'h0;
    end else if (ack_age != 4'hF) begin
      ack_age <= ack_age + 4'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ********
  // Assertions
  // ********
  chk_irq_held: assert property (
    $fell(WAKE_IRQ) |-> ack_age <= 4'h6)
    else $error("wake interrupt dropped without acknowledge");
  chk_reset_wins: assert property (
    CORE_RESTART |=> !$rose(WAKE_IRQ))
    else $error("wake raised with a periodic reset");
  chk_gate_quiet: assert property (
    (TR_POWER && !TEMP_IN_RESET)[*4] |=>
    !$rose(WAKE_IRQ) && !$rose(CORE_RESTART))
    else $error("wake or reset while thermally gated");
  chk_stop_power: assert property (
    STOP_REQ |-> TR_POWER)
    else $error("stop requested with restart unit off");
  chk_stop_pin: assert property (
    (TR_POWER && TEMP_LIMIT)[*4] |-> STOP_REQ)
    else $error("limit reached without stop request");
  chk_rd_answer: assert property (
    ARVALID && ARREADY |-> ##[1:3] RVALID)
    else $error("read answer late");
  chk_wr_answer: assert property (
    AWVALID && AWREADY |-> ##[1:4] BVALID)
    else $error("write answer late");
  chk_aw_pulse: assert property (
    AWREADY |=> !AWREADY)
    else $error("write address ready held");
endmodule
bind wake_timer wake_timer_asserts chk_u (
  .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .BVALID(BVALID),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .TEMP_IN_RESET(TEMP_IN_RESET), .TEMP_LIMIT(TEMP_LIMIT),
  .WAKE_IRQ(WAKE_IRQ), .CORE_RESTART(CORE_RESTART),
  .STOP_REQ(STOP_REQ), .TR_POWER(TR_POWER)
);
`default_nettype wire

// ===== verif/wake_timer_tb.sv
// Self-checking bench for the wake timer over its register bus.
// Assumes a core model on the far side and ticks driven from here.
`timescale 1ns/1ps
`default_nettype none
module wake_timer_tb;
  import wake_timer_pkg::*;
  // ********
  // Signals
  // ********
  logic CLK, RST, CORE_RST;
  logic CE = 1'b1;
  logic OSC_TICK = 1'b0, TEMP_IN_RESET = 1'b0, TEMP_IN_REARM = 1'b0;
  logic TEMP_LIMIT = 1'b0;
  logic [15:0] AWADDR = 16'h0000, ARADDR = 16'h0000;
  logic [31:0] WDATA = 32'h0000_0000, RDATA, rdat;
  logic [3:0] WSTRB = 4'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, wresp, rresp;
  logic WAKE_IRQ, CORE_RESTART, STOP_REQ, TR_POWER;
  logic [7:0] wakes, restarts;
  int fails = 0;
  int checked = 0;
  // ********
  // Design and core model
  // ********
  wake_timer dut_u (.CLK(CLK), .RST(RST), .CORE_RST(CORE_RST), .CE(CE),
    .OSC_TICK(OSC_TICK), .TEMP_IN_RESET(TEMP_IN_RESET),
    .TEMP_IN_REARM(TEMP_IN_REARM), .TEMP_LIMIT(TEMP_LIMIT),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .WAKE_IRQ(WAKE_IRQ),
    .CORE_RESTART(CORE_RESTART), .STOP_REQ(STOP_REQ), .TR_POWER(TR_POWER));
  core_model core_u (.clk(CLK), .rst(RST), .wake_irq(WAKE_IRQ),
    .restart(CORE_RESTART), .core_rst(CORE_RST), .wakes(wakes),
    .restarts(restarts));
  // Clock of 40 ns
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // ********
  // Tasks
  // ********
  // Compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  // Bus write, both halves offered together
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (int i = 0; i < 50 && !BVALID; i++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end
    chk("write answer", {31'h0, BVALID}, 32'h0000_0001);
    wresp = BRESP;
    BREADY <= 1'b0;
  endtask
  // Bus read
  task rd(input logic [15:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (int i = 0; i < 50 && !RVALID; i++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end
    chk("read answer", {31'h0, RVALID}, 32'h0000_0001);
    rdat = RDATA;
    rresp = RRESP;
    RREADY <= 1'b0;
  endtask
  // Read a register and compare
  task rchk(input logic [15:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, rdat, e);
  endtask
  // Oscillator ticks, then let the synchronisers settle
  task tk(input int n);
    repeat (n) begin
      OSC_TICK <= 1'b1;
      repeat (2) @(posedge CLK);
      OSC_TICK <= 1'b0;
      repeat (2) @(posedge CLK);
    end
    repeat (8) @(posedge CLK);
  endtask
  // Counts, verdict and end of run
  task end_sim;
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (40000) @(posedge CLK);
    fails++;
    end_sim;
  end
  // ********
  // Tests
  // ********
  initial begin
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    // Reset values and refused address
    rchk(OFS_WAKE_DIV, 32'h0000_001F, "divider");
    rchk(OFS_RESET_INTERVAL, 32'h0000_00BF, "reset int");
    rchk(OFS_OPTION_ONE, 32'h0000_0000, "option");
    rchk(OFS_TEST_STATUS, 32'h0000_0001, "armed");
    rd(16'h0100);
    chk("unmapped", {30'h0, rresp}, {30'h0, RESP_SLVERR});
    wr(16'h0100, 32'h0000_0000);
    chk("unmapped wr", {30'h0, wresp}, {30'h0, RESP_SLVERR});
    wr(OFS_RESET_INTERVAL, 32'h0000_0000);
    chk("write okay", {30'h0, wresp}, {30'h0, RESP_OKAY});
    rchk(OFS_RESET_INTERVAL, 32'h0000_0080, "never both off");
    $display("reset values done");
    // Reset and wake on the same cycle
    wr(OFS_WAKE_DIV, 32'h0000_0000);
    wr(OFS_WAKE_INTERVAL, 32'h0000_0000);
    wr(OFS_RESET_INTERVAL, 32'h0000_00C0);
    tk(503);
    chk("early reset", restarts, 8'h00);
    tk(1);
    chk("reset", restarts, 8'h01);
    chk("wake", {7'h0, WAKE_IRQ}, 1'b0);
    wr(OFS_WAKE_STATUS, 32'h0000_0001);
    rchk(OFS_WAKE_STATUS, 32'h0000_0001, "reset count");
    $display("precedence done");
    // Wake interval of two wake clocks, flag and acknowledge
    wr(OFS_RESET_INTERVAL, 32'h0000_0080);
    wr(OFS_WAKE_INTERVAL, 32'h0000_0001);
    wr(OFS_WAKE_STATUS, 32'h0000_0000);
    tk(504);
    chk("wake early", {7'h0, WAKE_IRQ}, 1'b0);
    rchk(OFS_WAKE_STATUS, 32'h0000_0100, "wake count");
    tk(504);
    chk("wake", {7'h0, WAKE_IRQ}, 1'b1);
    wr(OFS_WAKE_INTERVAL, 32'h0000_0001);
    rchk(OFS_WAKE_INTERVAL, 32'h0000_0081, "flag");
    rchk(OFS_WAKE_STATUS, 32'h0000_0000, "wake count");
    wr(OFS_WAKE_INTERVAL, 32'h0000_0041);
    repeat (3) @(posedge CLK);
    chk("wake cleared", {7'h0, WAKE_IRQ}, 1'b0);
    rchk(OFS_WAKE_INTERVAL, 32'h0000_0001, "flag");
    chk("wakes", wakes, 8'h01);
    $display("wake done");
    // Thermal gate, stop and recovery
    wr(OFS_RESET_INTERVAL, 32'h0000_00C0);
    wr(OFS_OPTION_ONE, 32'h0000_0008);
    rchk(OFS_OPTION_ONE, 32'h0000_0008, "enable");
    chk("power", {7'h0, TR_POWER}, 1'b1);
    TEMP_LIMIT <= 1'b1;
    tk(504);
    chk("stop", {7'h0, STOP_REQ}, 1'b1);
    rchk(OFS_WAKE_STATUS, 32'h0000_0100, "gated count");
    tk(504);
    chk("gated reset", restarts, 8'h01);
    chk("gated wake", wakes, 8'h01);
    rchk(OFS_WAKE_STATUS, 32'h0000_0000, "gated count");
    TEMP_LIMIT <= 1'b0;
    TEMP_IN_RESET <= 1'b1;
    tk(1);
    chk("recovery", restarts, 8'h02);
    chk("stop off", {31'h0, STOP_REQ}, 32'h0000_0000);
    rchk(OFS_OPTION_ONE, 32'h0000_0000, "core reset");
    rchk(OFS_TEST_STATUS, 32'h0000_0001, "armed");
    TEMP_IN_REARM <= 1'b1;
    tk(1);
    rchk(OFS_TEST_STATUS, 32'h0000_0000, "disarmed");
    wr(OFS_OPTION_ONE, 32'h0000_000C);
    rchk(OFS_OPTION_ONE, 32'h0000_0004, "enable refused");
    TEMP_IN_RESET <= 1'b0;
    TEMP_IN_REARM <= 1'b0;
    tk(1);
    rchk(OFS_TEST_STATUS, 32'h0000_0001, "rearmed");
    chk("no restart", restarts, 8'h02);
    $display("thermal done");
    end_sim;
  end
endmodule
`default_nettype wire
